// file: pkg/pump_regs_defs.vh
`ifndef PUMP_REGS_DEFS_VH
`define PUMP_REGS_DEFS_VH

// ----------------------------------------
// Function codes
// ----------------------------------------
`define FC_READ_HOLD      8'h03
`define FC_READ_INPUT     8'h04
`define FC_WRITE_SINGLE   8'h06
`define FC_WRITE_MULTI    8'h10

// ----------------------------------------
// Exception codes
// ----------------------------------------
`define EXC_NONE          8'h00
`define EXC_ILL_FUNC      8'h01
`define EXC_ILL_ADDR      8'h02

// ----------------------------------------
// Input register addresses
// ----------------------------------------
`define IN_FLOW_UNIT      16'h0110
`define IN_CAL_DATE_LO    16'h0111
`define IN_CAL_DATE_HI    16'h0112
`define IN_CAL_FAC_LO     16'h0113
`define IN_CAL_FAC_HI     16'h0114
`define IN_DOSE_COUNT     16'h0115
`define IN_INPUT_STATE    16'h0116
`define IN_OUTPUT_STATE   16'h0117
`define IN_CTRL_APPLIED   16'h0118
`define IN_SPEED_APPLIED  16'h0119
`define IN_FLOOR_APPLIED  16'h011a
`define IN_CEIL_APPLIED   16'h011b
`define IN_FS_SETUP_APPL  16'h011c
`define IN_FS_SPEED_APPL  16'h011d

// ----------------------------------------
// Holding register addresses
// ----------------------------------------
`define HR_CONTROL        16'h01ff
`define HR_SPEED          16'h0200
`define HR_CAL_FAC_LO     16'h0201
`define HR_CAL_FAC_HI     16'h0202
`define HR_SPEED_FLOOR    16'h0203
`define HR_SPEED_CEIL     16'h0204
`define HR_FS_SETUP       16'h0205
`define HR_FS_SPEED       16'h0206

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define CTRL_RUN_BIT      0
`define CTRL_DIR_BIT      1
`define CTRL_TACHO_BIT    2
`define CTRL_MINMAX_BIT   3
`define CTRL_CAL_LOAD_BIT 4
`define CTRL_CNT_CLR_BIT  5

// ----------------------------------------
// Reset values and flow unit codes
// ----------------------------------------
`define WORD_RESET        16'h0000
`define UNIT_ML_SEC       16'h0001
`define UNIT_ML_MIN       16'h0002
`define UNIT_G_SEC        16'h0003
`define UNIT_G_MIN        16'h0004
`define UNIT_L_HOUR       16'h0005
`define UNIT_LB_HOUR      16'h0006
`define UNIT_USG_HOUR     16'h0007

`endif

// file: src/dose_counter.v
`timescale 1ns/10ps
`include "pump_regs_defs.vh"

module dose_counter #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             rst_in,
  // Control
  input  wire             dose_done_in,
  input  wire             clear_in,
  // Count
  output reg  [WIDTH-1:0] count_out
);

  // Clear overrides a coincident dose so software sees a clean zero
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= {WIDTH{1'b0}};
    end else if (clear_in) begin
      count_out <= {WIDTH{1'b0}};
    end else if (dose_done_in) begin
      count_out <= count_out + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

// file: src/pump_fieldbus_register_map.v
`timescale 1ns/10ps
`include "pump_regs_defs.vh"


module pump_fieldbus_register_map (
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // Register request, one word per request
  input  wire        req_valid_in,
  input  wire [7:0]  req_func_in,
  input  wire [15:0] req_addr_in,
  input  wire [15:0] req_wdata_in,
  // Register answer
  output reg         rsp_valid_out,
  output reg  [15:0] rsp_data_out,
  output reg  [7:0]  rsp_exc_out,
  // Pump state
  input  wire        pump_active_in,
  input  wire        dose_done_in,
  input  wire [2:0]  flow_unit_in,
  input  wire [31:0] cal_date_in,
  input  wire [15:0] input_state_in,
  input  wire [15:0] output_state_in,
  // Applied settings and dose count
  output reg  [15:0] active_control_out,
  output reg  [15:0] active_speed_out,
  output reg  [15:0] active_floor_out,
  output reg  [15:0] active_ceiling_out,
  output reg  [15:0] active_fs_setup_out,
  output reg  [15:0] active_fs_speed_out,
  output reg  [31:0] active_cal_factor_out,
  output reg  [15:0] dose_count_out
);

  // ----------------------------------------
  // Pending holding registers
  // ----------------------------------------
  reg  [15:0] hold_ctrl_r;
  reg  [15:0] hold_speed_r;
  reg  [15:0] hold_cal_lo_r;
  reg  [15:0] hold_cal_hi_r;
  reg  [15:0] hold_floor_r;
  reg  [15:0] hold_ceil_r;
  reg  [15:0] hold_fs_setup_r;
  reg  [15:0] hold_fs_speed_r;

  wire [15:0] count_w;
  wire        is_hold_addr;
  wire        is_input_addr;
  wire        is_write;
  wire        wr_ok;
  wire        counter_clear;

  reg  [15:0] rd_data_nxt;
  reg  [7:0]  exc_nxt;
  reg  [15:0] unit_code;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign is_hold_addr  = (req_addr_in >= `HR_CONTROL) && (req_addr_in <= `HR_FS_SPEED);
  assign is_input_addr = (req_addr_in >= `IN_FLOW_UNIT) && (req_addr_in <= `IN_FS_SPEED_APPL);
  assign is_write      = (req_func_in == `FC_WRITE_SINGLE) || (req_func_in == `FC_WRITE_MULTI);
  assign wr_ok         = req_valid_in && is_write && is_hold_addr;
  // Clear is a control-word action, so it waits for a stopped pump
  assign counter_clear = active_control_out[`CTRL_CNT_CLR_BIT];

  // Out-of-range pump codes read as zero rather than a bogus unit
  always @* begin
    unit_code = `WORD_RESET;
    if (flow_unit_in != 3'h0) begin
      unit_code = {13'h0000, flow_unit_in};
    end
  end

  // ----------------------------------------
  // Holding register writes
  // ----------------------------------------
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_ctrl_r     <= `WORD_RESET;
      hold_speed_r    <= `WORD_RESET;
      hold_cal_lo_r   <= `WORD_RESET;
      hold_cal_hi_r   <= `WORD_RESET;
      hold_floor_r    <= `WORD_RESET;
      hold_ceil_r     <= `WORD_RESET;
      hold_fs_setup_r <= `WORD_RESET;
      hold_fs_speed_r <= `WORD_RESET;
    end else if (wr_ok) begin
      case (req_addr_in)
        `HR_CONTROL: begin
          hold_ctrl_r <= req_wdata_in;
        end
        `HR_SPEED: begin
          hold_speed_r <= req_wdata_in;
        end
        `HR_CAL_FAC_LO: begin
          hold_cal_lo_r <= req_wdata_in;
        end
        `HR_CAL_FAC_HI: begin
          hold_cal_hi_r <= req_wdata_in;
        end
        `HR_SPEED_FLOOR: begin
          hold_floor_r <= req_wdata_in;
        end
        `HR_SPEED_CEIL: begin
          hold_ceil_r <= req_wdata_in;
        end
        `HR_FS_SETUP: begin
          hold_fs_setup_r <= req_wdata_in;
        end
        `HR_FS_SPEED: begin
          hold_fs_speed_r <= req_wdata_in;
        end
        default: begin
          hold_ctrl_r <= hold_ctrl_r;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pending to applied transfer
  // ----------------------------------------
  // Transfer is continuous while stopped, the cal factor only while the
  // holding control word has the cal-load bit set; a write that lands while
  // running simply sits in the holding copy until the pump stops.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      active_control_out    <= `WORD_RESET;
      active_speed_out      <= `WORD_RESET;
      active_floor_out      <= `WORD_RESET;
      active_ceiling_out    <= `WORD_RESET;
      active_fs_setup_out   <= `WORD_RESET;
      active_fs_speed_out   <= `WORD_RESET;
      active_cal_factor_out <= 32'h0000_0000;
    end else if (!pump_active_in) begin
      active_control_out  <= hold_ctrl_r;
      active_speed_out    <= hold_speed_r;
      active_floor_out    <= hold_floor_r;
      active_ceiling_out  <= hold_ceil_r;
      active_fs_setup_out <= hold_fs_setup_r;
      active_fs_speed_out <= hold_fs_speed_r;
      if (hold_ctrl_r[`CTRL_CAL_LOAD_BIT]) begin
        active_cal_factor_out <= {hold_cal_hi_r, hold_cal_lo_r};
      end
    end
  end

  // ----------------------------------------
  // Dose counter
  // ----------------------------------------
  dose_counter #(
    .WIDTH (16)
  ) u_dose_counter (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .dose_done_in (dose_done_in),
    .clear_in     (counter_clear),
    .count_out    (count_w)
  );

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dose_count_out <= `WORD_RESET;
    end else begin
      dose_count_out <= count_w;
    end
  end

  // ----------------------------------------
  // Read mux and exception selection
  // ----------------------------------------
  always @* begin
    rd_data_nxt = `WORD_RESET;
    exc_nxt     = `EXC_NONE;
    case (req_func_in)
      `FC_READ_INPUT: begin
        if (!is_input_addr) begin
          exc_nxt = `EXC_ILL_ADDR;
        end
        case (req_addr_in)
          `IN_FLOW_UNIT:     rd_data_nxt = unit_code;
          `IN_CAL_DATE_LO:   rd_data_nxt = cal_date_in[15:0];
          `IN_CAL_DATE_HI:   rd_data_nxt = cal_date_in[31:16];
          `IN_CAL_FAC_LO:    rd_data_nxt = active_cal_factor_out[15:0];
          `IN_CAL_FAC_HI:    rd_data_nxt = active_cal_factor_out[31:16];
          `IN_DOSE_COUNT:    rd_data_nxt = count_w;
          `IN_INPUT_STATE:   rd_data_nxt = input_state_in;
          `IN_OUTPUT_STATE:  rd_data_nxt = output_state_in;
          `IN_CTRL_APPLIED:  rd_data_nxt = active_control_out;
          `IN_SPEED_APPLIED: rd_data_nxt = active_speed_out;
          `IN_FLOOR_APPLIED: rd_data_nxt = active_floor_out;
          `IN_CEIL_APPLIED:  rd_data_nxt = active_ceiling_out;
          `IN_FS_SETUP_APPL: rd_data_nxt = active_fs_setup_out;
          `IN_FS_SPEED_APPL: rd_data_nxt = active_fs_speed_out;
          default:           rd_data_nxt = `WORD_RESET;
        endcase
      end
      `FC_READ_HOLD: begin
        if (!is_hold_addr) begin
          exc_nxt = `EXC_ILL_ADDR;
        end
        case (req_addr_in)
          `HR_CONTROL:     rd_data_nxt = hold_ctrl_r;
          `HR_SPEED:       rd_data_nxt = hold_speed_r;
          `HR_CAL_FAC_LO:  rd_data_nxt = hold_cal_lo_r;
          `HR_CAL_FAC_HI:  rd_data_nxt = hold_cal_hi_r;
          `HR_SPEED_FLOOR: rd_data_nxt = hold_floor_r;
          `HR_SPEED_CEIL:  rd_data_nxt = hold_ceil_r;
          `HR_FS_SETUP:    rd_data_nxt = hold_fs_setup_r;
          `HR_FS_SPEED:    rd_data_nxt = hold_fs_speed_r;
          default:         rd_data_nxt = `WORD_RESET;
        endcase
      end
      `FC_WRITE_SINGLE, `FC_WRITE_MULTI: begin
        // Input words are read-only; only the holding window takes data
        if (!is_hold_addr) begin
          exc_nxt = `EXC_ILL_ADDR;
        end
        rd_data_nxt = req_wdata_in;
      end
      default: begin
        exc_nxt = `EXC_ILL_FUNC;
      end
    endcase
  end

  // ----------------------------------------
  // Registered answer
  // ----------------------------------------
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_data_out  <= `WORD_RESET;
      rsp_exc_out   <= `EXC_NONE;
    end else begin
      rsp_valid_out <= req_valid_in;
      if (req_valid_in) begin
        rsp_data_out <= (exc_nxt == `EXC_NONE) ? rd_data_nxt : `WORD_RESET;
        rsp_exc_out  <= exc_nxt;
      end
    end
  end

endmodule

// file: tb/pump_regs_assertions.sv
`timescale 1ns/10ps
`include "pump_regs_defs.vh"
module pump_regs_checker (
  // Clock and reset
  input wire        clk_in,
  input wire        rst_in,
  // Request and answer
  input wire        req_valid_in,
  input wire [7:0]  req_func_in,
  input wire [15:0] req_addr_in,
  input wire [15:0] req_wdata_in,
  input wire        rsp_valid_out,
  input wire [15:0] rsp_data_out,
  input wire [7:0]  rsp_exc_out,
  // Pump side
  input wire        pump_active_in,
  input wire [2:0]  flow_unit_in,
  input wire [31:0] cal_date_in,
  input wire [15:0] active_control_out,
  input wire [15:0] active_speed_out,
  input wire [15:0] active_floor_out,
  input wire [15:0] active_ceiling_out,
  input wire [15:0] active_fs_setup_out,
  input wire [15:0] active_fs_speed_out,
  input wire [15:0] dose_count_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire rd_in  = req_valid_in && req_func_in == `FC_READ_INPUT;
  wire in_map = req_addr_in >= `IN_FLOW_UNIT && req_addr_in <= `IN_FS_SPEED_APPL;
  wire bad_fc = !(req_func_in inside {8'h03, 8'h04, 8'h06, 8'h10});
  sequence s_speed_wr;
    req_valid_in && req_func_in == `FC_WRITE_SINGLE && req_addr_in == `HR_SPEED;
  endsequence
  property p_answer; req_valid_in |=> rsp_valid_out; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_quiet; !req_valid_in |=> !rsp_valid_out; endproperty
  a_quiet: assert property (p_quiet) else $error("stray answer");
  property p_bad_fc; req_valid_in && bad_fc |=> rsp_exc_out == `EXC_ILL_FUNC; endproperty
  a_bad_fc: assert property (p_bad_fc) else $error("bad code taken");
  property p_in_ok; rd_in && in_map |=> rsp_exc_out == `EXC_NONE; endproperty
  a_in_ok: assert property (p_in_ok) else $error("input read refused");
  property p_in_ro;
    req_valid_in && req_func_in == `FC_WRITE_SINGLE && in_map |=> rsp_exc_out == `EXC_ILL_ADDR;
  endproperty
  a_in_ro: assert property (p_in_ro) else $error("input write taken");
  property p_flow; rd_in && req_addr_in == `IN_FLOW_UNIT |=> rsp_data_out == {13'h0000, $past(flow_unit_in)}; endproperty
  a_flow: assert property (p_flow) else $error("unit code wrong");
  property p_date; rd_in && req_addr_in == `IN_CAL_DATE_HI |=> {16'h0000, rsp_data_out} == $past(cal_date_in) >> 16;
  endproperty
  a_date: assert property (p_date) else $error("date high wrong");
  property p_freeze;
    pump_active_in |=> $stable({active_control_out, active_speed_out, active_floor_out,
                                active_ceiling_out, active_fs_setup_out, active_fs_speed_out});
  endproperty
  a_freeze: assert property (p_freeze) else $error("applied moved while running");
  property p_apply; s_speed_wr ##1 !pump_active_in |=> active_speed_out == $past(req_wdata_in, 2); endproperty
  a_apply: assert property (p_apply) else $error("speed not applied");
  property p_clear; active_control_out[`CTRL_CNT_CLR_BIT] [*2] |=> dose_count_out == 16'h0000; endproperty
  a_clear: assert property (p_clear) else $error("count not cleared");
endmodule
bind pump_fieldbus_register_map pump_regs_checker i_chk (.clk_in, .rst_in, .req_valid_in, .req_func_in,
  .req_addr_in, .req_wdata_in, .rsp_valid_out, .rsp_data_out, .rsp_exc_out, .pump_active_in, .flow_unit_in,
  .cal_date_in, .active_control_out, .active_speed_out, .active_floor_out, .active_ceiling_out,
  .active_fs_setup_out, .active_fs_speed_out, .dose_count_out);

// file: tb/fieldbus_master.sv
`timescale 1ns/10ps
module fieldbus_master (
  // Clock
  input  wire        clk_in,
  // Request
  output reg         req_valid_out,
  output reg  [7:0]  req_func_out,
  output reg  [15:0] req_addr_out,
  output reg  [15:0] req_wdata_out,
  // Answer
  input  wire        rsp_valid_in,
  input  wire [15:0] rsp_data_in,
  input  wire [7:0]  rsp_exc_in
);
  initial begin
    req_valid_out = 1'b0;
    req_func_out = 8'h00;
    req_addr_out = 16'h0000;
    req_wdata_out = 16'h0000;
  end
  // One word a request, answer due at the next edge
  task xfer(input [7:0] f, input [15:0] a, d, output [15:0] q, output [7:0] e);
    begin
      @(posedge clk_in);
      req_valid_out <= 1'b1;
      req_func_out <= f;
      req_addr_out <= a;
      req_wdata_out <= d;
      @(posedge clk_in);
      req_valid_out <= 1'b0;
      // Released address and data lines flip so stale values cannot pass; the function code is held
      req_addr_out <= ~a;
      req_wdata_out <= ~d;
      @(posedge clk_in);
      q = rsp_valid_in ? rsp_data_in : ~rsp_data_in;
      e = rsp_valid_in ? rsp_exc_in : 8'hee;
    end
  endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/10ps
`include "pump_regs_defs.vh"
module testbench;
  reg         clk_in = 1'b0;
  reg         rst_in = 1'b1;
  reg         pump_active_in = 1'b0;
  reg         dose_done_in = 1'b0;
  reg  [2:0]  flow_unit_in = 3'h0;
  reg  [31:0] cal_date_in = 32'h0;
  reg  [15:0] input_state_in = 16'h0;
  reg  [15:0] output_state_in = 16'h0;
  wire        req_valid, rsp_valid;
  wire [7:0]  req_func, rsp_exc;
  wire [15:0] req_addr, req_wdata, rsp_data, dose_cnt;
  // Applied copies, lowest slice is the control word
  wire [95:0] act_all;
  wire [31:0] act_cal;
  reg  [15:0] hv [0:7];
  reg  [15:0] q, w, ad;
  reg  [7:0]  e;
  integer     error_cnt = 0, compares = 0, i, n;
  always #20 clk_in = ~clk_in;
  fieldbus_master i_mst (.clk_in(clk_in), .req_valid_out(req_valid), .req_func_out(req_func),
    .req_addr_out(req_addr), .req_wdata_out(req_wdata), .rsp_valid_in(rsp_valid), .rsp_data_in(rsp_data),
    .rsp_exc_in(rsp_exc));
  pump_fieldbus_register_map i_dut (.clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid),
    .req_func_in(req_func), .req_addr_in(req_addr), .req_wdata_in(req_wdata), .rsp_valid_out(rsp_valid),
    .rsp_data_out(rsp_data), .rsp_exc_out(rsp_exc), .pump_active_in(pump_active_in),
    .dose_done_in(dose_done_in), .flow_unit_in(flow_unit_in), .cal_date_in(cal_date_in),
    .input_state_in(input_state_in), .output_state_in(output_state_in), .active_control_out(act_all[15:0]),
    .active_speed_out(act_all[31:16]), .active_floor_out(act_all[47:32]), .active_ceiling_out(act_all[63:48]),
    .active_fs_setup_out(act_all[79:64]), .active_fs_speed_out(act_all[95:80]),
    .active_cal_factor_out(act_cal), .dose_count_out(dose_cnt));
  task chk(input [15:0] seen, exp, what);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] reg %h exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task acc(input [7:0] f, input [15:0] a, d, ed, input [7:0] ee);
    begin
      i_mst.xfer(f, a, d, q, e);
      chk(q, ed, a);
      chk({8'h00, e}, {8'h00, ee}, a);
    end
  endtask
  task final_report;
    begin
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Holding index to its applied twin
  function [15:0] ap(input integer k);
    ap = (k < 2) ? 16'(16'h0118 + k) : 16'(16'h0116 + k);
  endfunction
  initial begin
    #800000;
    error_cnt = error_cnt + 1;
    final_report;
  end
  // ----
  // Tests
  // ----
  initial begin
    n = $urandom(32'hbff3);
    for (i = 0; i < 8; i = i + 1) hv[i] = 16'h0000;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    for (i = 1; i < 8; i = i + 1) begin
      @(posedge clk_in) flow_unit_in <= i[2:0];
      acc(`FC_READ_INPUT, `IN_FLOW_UNIT, 16'h0, i[15:0], `EXC_NONE);
    end
    @(posedge clk_in) begin
      cal_date_in <= $urandom;
      input_state_in <= 16'($urandom);
      output_state_in <= 16'($urandom);
    end
    // Let the new levels land before they are used as expectations
    @(negedge clk_in);
    acc(`FC_READ_INPUT, `IN_CAL_DATE_LO, 16'h0, cal_date_in[15:0], `EXC_NONE);
    acc(`FC_READ_INPUT, `IN_CAL_DATE_HI, 16'h0, cal_date_in[31:16], `EXC_NONE);
    acc(`FC_READ_INPUT, `IN_INPUT_STATE, 16'h0, input_state_in, `EXC_NONE);
    acc(`FC_READ_INPUT, `IN_OUTPUT_STATE, 16'h0, output_state_in, `EXC_NONE);
    $display("inputs done");
    n = 3 + $urandom % 8;
    repeat (n) begin
      @(posedge clk_in) dose_done_in <= 1'b1;
      @(posedge clk_in) dose_done_in <= 1'b0;
    end
    acc(`FC_READ_INPUT, `IN_DOSE_COUNT, 16'h0, n[15:0], `EXC_NONE);
    chk(dose_cnt, n[15:0], `IN_DOSE_COUNT);
    acc(`FC_WRITE_SINGLE, `HR_CONTROL, 16'h0020, 16'h0020, `EXC_NONE);
    acc(`FC_READ_INPUT, `IN_DOSE_COUNT, 16'h0, 16'h0, `EXC_NONE);
    acc(`FC_WRITE_SINGLE, `HR_CONTROL, 16'h0, 16'h0, `EXC_NONE);
    $display("doses done");
    @(posedge clk_in) pump_active_in <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      ad = 16'(`HR_CONTROL + i);
      w = (i == 0) ? 16'($urandom) & 16'hffcf : 16'($urandom);
      acc(i[0] ? `FC_WRITE_MULTI : `FC_WRITE_SINGLE, ad, w, w, `EXC_NONE);
      acc(`FC_READ_HOLD, ad, 16'h0, w, `EXC_NONE);
      if (i != 2 && i != 3) acc(`FC_READ_INPUT, ap(i), 16'h0, hv[i], `EXC_NONE);
      hv[i] = w;
    end
    @(posedge clk_in) pump_active_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    for (i = 0; i < 8; i = i + 1)
      if (i != 2 && i != 3) begin
        acc(`FC_READ_INPUT, ap(i), 16'h0, hv[i], `EXC_NONE);
        chk(act_all[16*(i < 2 ? i : i - 2) +: 16], hv[i], ap(i));
      end
    acc(`FC_READ_INPUT, `IN_CAL_FAC_LO, 16'h0, 16'h0, `EXC_NONE);
    chk(act_cal[15:0], 16'h0000, `IN_CAL_FAC_LO);
    w = hv[0] | 16'h0010;
    acc(`FC_WRITE_SINGLE, `HR_CONTROL, w, w, `EXC_NONE);
    acc(`FC_READ_INPUT, `IN_CAL_FAC_LO, 16'h0, hv[2], `EXC_NONE);
    acc(`FC_READ_INPUT, `IN_CAL_FAC_HI, 16'h0, hv[3], `EXC_NONE);
    chk(act_cal[15:0], hv[2], `IN_CAL_FAC_LO);
    chk(act_cal[31:16], hv[3], `IN_CAL_FAC_HI);
    w = 16'($urandom);
    acc(`FC_WRITE_SINGLE, `HR_SPEED, w, w, `EXC_NONE);
    acc(`FC_READ_INPUT, `IN_SPEED_APPLIED, 16'h0, w, `EXC_NONE);
    chk(act_all[31:16], w, `IN_SPEED_APPLIED);
    $display("settings done");
    acc(`FC_WRITE_SINGLE, `IN_DOSE_COUNT, 16'h1234, 16'h0, `EXC_ILL_ADDR);
    acc(`FC_WRITE_MULTI, `IN_FLOW_UNIT, 16'h1234, 16'h0, `EXC_ILL_ADDR);
    acc(`FC_READ_INPUT, `HR_SPEED, 16'h0, 16'h0, `EXC_ILL_ADDR);
    acc(`FC_READ_INPUT, 16'h011e, 16'h0, 16'h0, `EXC_ILL_ADDR);
    acc(`FC_READ_HOLD, 16'h0207, 16'h0, 16'h0, `EXC_ILL_ADDR);
    acc(8'h05, `HR_SPEED, 16'h0, 16'h0, `EXC_ILL_FUNC);
    acc(`FC_READ_INPUT, `IN_DOSE_COUNT, 16'h0, 16'h0, `EXC_NONE);
    $display("refusals done");
    final_report;
  end
endmodule
